// ==== logic/axc_unit.sv ====
// accumulator xor / compare execution unit
// Overview of operation
// - xor double: accumulator xor immediate constant, result back to accumulator.
// - immediate port is a full 32 bits; constants limited to 16 fit too.
// - after every xor the zero flag shows whether the result is zero.
// - after every xor the negative flag copies result bit 31.
// - flags hold until an operation writing that same flag runs.
// - formatted xor gathers 1..32 consecutive bits and xors them with accumulator.
// - formatted xor takes start bits plus count; counts outside 1..32 are rejected.
// - formatted xor sets negative flag from result bit 31.
// - stack xor: accumulator xor top stack entry into accumulator.
// - stack xor pops top entry; remaining entries move up one level.
// - compare uses accumulator low 16 bits against a 16-bit memory word.
// - compare sets less flag when accumulator is smaller.
// - compare sets equal flag when values match.
// - compare sets greater flag when accumulator is larger.
`timescale 1ns/1ns
`default_nettype none
module axc_unit
  import axc_pkg::*;
#(
  parameter int DEPTH = STACK_DEPTH
)
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic op_valid_in,
  input wire axc_op_type op_in,
  input wire logic [ACC_W-1:0] immediate_in,
  input wire logic [ACC_W-1:0] discrete_bits_in,
  input wire logic [5:0] bit_count_in,
  input wire logic [WORD_W-1:0] memory_word_in,
  input wire logic [ACC_W-1:0] load_value_in,
  output logic [ACC_W-1:0] accumulator_out,
  output logic [ACC_W-1:0] stack_top_out,
  output logic zero_result_flag_out,
  output logic negative_result_flag_out,
  output logic less_than_flag_out,
  output logic equal_flag_out,
  output logic greater_than_flag_out,
  output logic bad_count_out,
  output logic done_out
);
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] stack_r [DEPTH];
  logic [ACC_W-1:0] pattern;
  logic count_ok;
  logic [ACC_W-1:0] xor_nxt;
  logic is_xor;
  logic [WORD_W-1:0] acc_lo;

  // formatted bit run gatherer
  axc_bit_gather #(.WIDTH(ACC_W)) u_gather
  (
    .bits_in(discrete_bits_in),
    .count_in(bit_count_in),
    .pattern_out(pattern),
    .count_ok_out(count_ok)
  );

  assign acc_lo = acc_r[WORD_W-1:0];

  // select xor operand per operation
  always_comb
  begin
    is_xor = 1'b0;
    xor_nxt = acc_r;
    if (op_valid_in)
    begin
      case (op_in)
        AXC_OP_XOR_DOUBLE_IMMEDIATE:
        begin
          is_xor = 1'b1;
          xor_nxt = acc_r ^ immediate_in;
        end
        AXC_OP_XOR_FORMATTED_BITS:
        begin
          is_xor = count_ok;
          xor_nxt = acc_r ^ pattern;
        end
        AXC_OP_XOR_WITH_STACK_TOP:
        begin
          is_xor = 1'b1;
          xor_nxt = acc_r ^ stack_r[0];
        end
        default:
        begin
          is_xor = 1'b0;
          xor_nxt = acc_r;
        end
      endcase
    end
  end

  // accumulator update; compare leaves it alone
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      acc_r <= ACC_RST;
    else if (is_xor)
      acc_r <= xor_nxt;
    else if (op_valid_in && op_in == AXC_OP_LOAD)
      acc_r <= load_value_in;
  end

  // stack: push on load-style push, pop on stack xor
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      for (int i = 0; i < DEPTH; i++)
        stack_r[i] <= ACC_RST;
    end
    else if (op_valid_in && op_in == AXC_OP_XOR_WITH_STACK_TOP)
    begin
      for (int i = 0; i < DEPTH - 1; i++)
        stack_r[i] <= stack_r[i+1];
      stack_r[DEPTH-1] <= ACC_RST;
    end
    else if (op_valid_in && op_in == AXC_OP_PUSH)
    begin
      for (int i = DEPTH - 1; i > 0; i--)
        stack_r[i] <= stack_r[i-1];
      stack_r[0] <= acc_r;
    end
  end

  // zero and negative flags written only by xor operations
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      zero_result_flag_out <= 1'b0;
      negative_result_flag_out <= 1'b0;
    end
    else if (is_xor)
    begin
      zero_result_flag_out <= (xor_nxt == ACC_RST);
      negative_result_flag_out <= xor_nxt[ACC_W-1];
    end
  end

  // compare flags written only by compare, unsigned ordering
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      less_than_flag_out <= 1'b0;
      equal_flag_out <= 1'b0;
      greater_than_flag_out <= 1'b0;
    end
    else if (op_valid_in && op_in == AXC_OP_COMPARE_WORD)
    begin
      less_than_flag_out <= (acc_lo < memory_word_in);
      equal_flag_out <= (acc_lo == memory_word_in);
      greater_than_flag_out <= (acc_lo > memory_word_in);
    end
  end

  // status: rejected count and completion pulse
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      bad_count_out <= 1'b0;
      done_out <= 1'b0;
    end
    else
    begin
      bad_count_out <= op_valid_in && op_in == AXC_OP_XOR_FORMATTED_BITS && !count_ok;
      done_out <= op_valid_in && op_in != AXC_OP_NONE;
    end
  end

  // registered mirrors of accumulator and stack top
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      accumulator_out <= ACC_RST;
      stack_top_out <= ACC_RST;
    end
    else
    begin
      accumulator_out <= acc_r;
      stack_top_out <= stack_r[0];
    end
  end
endmodule
`default_nettype wire

// ==== logic/axc_pkg.sv ====
// package with constants and types for the accumulator xor/compare unit
package axc_pkg;
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int STACK_DEPTH = 8;
  localparam int CNT_W = 6;
  localparam logic [5:0] BITCNT_MIN = 6'h01;
  localparam logic [5:0] BITCNT_MAX = 6'h20;
  localparam logic [31:0] ACC_RST = 32'h0000_0000;
  typedef enum logic [2:0]
  {
    AXC_OP_NONE,
    AXC_OP_XOR_DOUBLE_IMMEDIATE,
    AXC_OP_XOR_FORMATTED_BITS,
    AXC_OP_XOR_WITH_STACK_TOP,
    AXC_OP_COMPARE_WORD,
    AXC_OP_PUSH,
    AXC_OP_LOAD
  } axc_op_type;
endpackage

// ==== logic/axc_bit_gather.sv ====
// gathers a run of discrete bits into a right-aligned 32-bit pattern
`timescale 1ns/1ns
`default_nettype none
module axc_bit_gather
  import axc_pkg::*;
#(
  parameter int WIDTH = 32
)
(
  input wire logic [WIDTH-1:0] bits_in,
  input wire logic [5:0] count_in,
  output logic [WIDTH-1:0] pattern_out,
  output logic count_ok_out
);
  // count outside 1..32 is flagged invalid
  assign count_ok_out = (count_in >= BITCNT_MIN) && (count_in <= BITCNT_MAX);
  // keep only the lowest count bits of the run
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1)
    begin : g_mask
      assign pattern_out[gi] = bits_in[gi] & (6'(gi) < count_in);
    end
  endgenerate
endmodule
`default_nettype wire

// ==== tb/axc_unit_chk.sv ====
// assertion checker for the accumulator xor/compare unit
`timescale 1ns/1ns
`default_nettype none
module axc_unit_chk
  import axc_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic op_valid_in,
  input wire axc_op_type op_in,
  input wire logic [5:0] bit_count_in,
  input wire logic [ACC_W-1:0] accumulator_out,
  input wire logic zero_result_flag_out,
  input wire logic negative_result_flag_out,
  input wire logic less_than_flag_out,
  input wire logic equal_flag_out,
  input wire logic greater_than_flag_out,
  input wire logic bad_count_out
);
  // decode of the op taken at this edge
  wire logic fx = op_in == AXC_OP_XOR_FORMATTED_BITS;
  wire logic bad = op_valid_in && fx && (bit_count_in == 6'h00 || bit_count_in > 6'h20);
  wire logic cmp = op_valid_in && op_in == AXC_OP_COMPARE_WORD;
  wire logic xop = op_valid_in && !bad && (fx || op_in == AXC_OP_XOR_DOUBLE_IMMEDIATE
    || op_in == AXC_OP_XOR_WITH_STACK_TOP);
  wire logic [2:0] cf = {less_than_flag_out, equal_flag_out, greater_than_flag_out};
  wire logic [1:0] xf = {zero_result_flag_out, negative_result_flag_out};
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // flags answer one edge after the op, accumulator one edge later
  rej_pulse_a: assert property (bad |=> bad_count_out)
    else $error("no refusal pulse");
  rej_acc_a: assert property (bad |=> ##1 $stable(accumulator_out))
    else $error("refused op moved acc");
  rej_flag_a: assert property (bad |=> $stable(xf))
    else $error("refused op moved flags");
  cmp_hot_a: assert property (cmp |=> $onehot(cf))
    else $error("compare flags not one hot");
  cmp_acc_a: assert property (cmp |=> ##1 $stable(accumulator_out))
    else $error("compare moved acc");
  cmp_keep_a: assert property (cmp |=> $stable(xf))
    else $error("compare moved xor flags");
  xor_keep_a: assert property (xop |=> $stable(cf))
    else $error("xor moved compare flags");
  zero_flag_a: assert property (xop |=> ##1 $past(zero_result_flag_out) == (accumulator_out == 0))
    else $error("zero flag wrong");
  neg_flag_a: assert property (xop |=> ##1 $past(negative_result_flag_out) == accumulator_out[31])
    else $error("negative flag wrong");
endmodule
bind axc_unit axc_unit_chk chk_u (.clk_in, .srst_in, .op_valid_in, .op_in, .bit_count_in,
  .accumulator_out, .zero_result_flag_out, .negative_result_flag_out, .less_than_flag_out,
  .equal_flag_out, .greater_than_flag_out, .bad_count_out);
`default_nettype wire

// ==== tb/axc_unit_tb.sv ====
// self-checking bench for the accumulator xor/compare unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, s) check_count++; if ((s) !== (e)) bad(nm, e, s);
module axc_unit_tb
  import axc_pkg::*;
;
  logic clk_in = 0, srst_in = 1, v = 0, pd = 0;
  axc_op_type op = AXC_OP_NONE;
  logic [31:0] a_r = 0, ma = 0, acc, st;
  logic [5:0] c_r = 1;
  logic [7:0][31:0] ms = 0;
  logic [4:0] mf = 0;
  logic [68:0] q[$], pe;
  logic z, n, lt, eq, gt, dn;
  int num_errors = 0, check_count = 0, seed = 11235, cyc = 0;
  // one driven word feeds every operand input except bit_count_in
  axc_unit dut_u (.clk_in, .srst_in, .op_valid_in(v), .op_in(op), .immediate_in(a_r),
    .discrete_bits_in(a_r), .bit_count_in(c_r), .memory_word_in(a_r[15:0]),
    .load_value_in(a_r), .accumulator_out(acc), .stack_top_out(st),
    .zero_result_flag_out(z), .negative_result_flag_out(n), .less_than_flag_out(lt),
    .equal_flag_out(eq), .greater_than_flag_out(gt), .bad_count_out(), .done_out(dn));
  // clock and cycle ceiling
  always #5 clk_in = ~clk_in;
  always @(posedge clk_in)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      num_errors++;
      close_out;
    end
  end
  task bad(input string nm, input logic [68:0] e, s);
    $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    num_errors++;
  endtask
  task close_out;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // issue one op and note the expected acc, stack top and flags
  task run(input axc_op_type o, input logic [31:0] a, input logic [5:0] c);
    logic ok;
    ok = o != AXC_OP_XOR_FORMATTED_BITS || (c != 0 && c <= 6'h20);
    case (o)
      AXC_OP_LOAD: ma = a;
      AXC_OP_PUSH: ms = {ms[6:0], ma};
      AXC_OP_XOR_DOUBLE_IMMEDIATE: ma = ma ^ a;
      AXC_OP_XOR_FORMATTED_BITS: if (ok) ma = ma ^ (a & (32'hffff_ffff >> (6'h20 - c)));
      AXC_OP_XOR_WITH_STACK_TOP:
      begin
        ma = ma ^ ms[0];
        ms = {32'h0000_0000, ms[7:1]};
      end
      AXC_OP_COMPARE_WORD: mf[2:0] = {ma[15:0] < a[15:0], ma[15:0] == a[15:0], ma[15:0] > a[15:0]};
      default: ;
    endcase
    if (ok && o inside {AXC_OP_XOR_DOUBLE_IMMEDIATE, AXC_OP_XOR_FORMATTED_BITS,
      AXC_OP_XOR_WITH_STACK_TOP})
      mf[4:3] = {ma == 0, ma[31]};
    if (ok)
      q.push_back({ma, ms[0], mf});
    op <= o;
    a_r <= a;
    c_r <= c;
    v <= 1;
    @(posedge clk_in);
  endtask
  task idle;
    v <= 0;
    repeat (4) @(posedge clk_in);
  endtask
  // flags on the done cycle, acc and stack top one cycle later
  always @(negedge clk_in)
  begin
    if (pd)
    begin
      `CHK("acc_top", pe[68:5], {acc, st})
    end
    pd = 0;
    if (dn === 1'b1 && q.size() > 0)
    begin
      pe = q.pop_front();
      `CHK("flags", pe[4:0], {z, n, lt, eq, gt})
      pd = 1;
    end
  end
  // directed corners, refusals, then random back-to-back ops
  initial
  begin
    repeat (12) @(posedge clk_in);
    srst_in <= 0;
    run(AXC_OP_LOAD, 32'h8000_0001, 6'h01);
    run(AXC_OP_COMPARE_WORD, 32'h0000_8000, 6'h01);
    run(AXC_OP_PUSH, 32'h0000_0000, 6'h01);
    run(AXC_OP_XOR_WITH_STACK_TOP, 32'h0000_0000, 6'h01);
    run(AXC_OP_COMPARE_WORD, 32'h0000_0000, 6'h01);
    run(AXC_OP_XOR_DOUBLE_IMMEDIATE, 32'hffff_ffff, 6'h01);
    run(AXC_OP_XOR_FORMATTED_BITS, 32'hffff_ffff, 6'h20);
    run(AXC_OP_XOR_FORMATTED_BITS, 32'hffff_ffff, 6'h01);
    idle;
    run(AXC_OP_XOR_FORMATTED_BITS, 32'h1234_5678, 6'h00);
    idle;
    run(AXC_OP_XOR_FORMATTED_BITS, 32'h1234_5678, 6'h21);
    idle;
    for (int i = 0; i < 300; i++)
      run(axc_op_type'(1 + $unsigned($random(seed)) % 6), $random(seed),
        6'(1 + $unsigned($random(seed)) % 32));
    idle;
    close_out;
  end
endmodule
`default_nettype wire
